// *** farc_pkg.sv ***
// Shared types and constants for the fault auto-retry controller.
// Assumes one core clock at 125 MHz and fault codes from logic on that same clock.
package farc_pkg;

  // Major fault codes as reported by the protective logic.
  localparam logic [5:0] ACCEL_OVERCURRENT_FAULT = 6'h01;
  localparam logic [5:0] CONST_SPEED_OVERCURRENT_FAULT = 6'h02;
  localparam logic [5:0] DECEL_OVERCURRENT_FAULT = 6'h03;
  localparam logic [5:0] ACCEL_OVERVOLTAGE_FAULT = 6'h04;
  localparam logic [5:0] CONST_SPEED_OVERVOLTAGE_FAULT = 6'h05;
  localparam logic [5:0] DECEL_OVERVOLTAGE_FAULT = 6'h06;
  localparam logic [5:0] MOTOR_THERMAL_FAULT = 6'h07;
  localparam logic [5:0] TRANSISTOR_THERMAL_FAULT = 6'h08;
  localparam logic [5:0] POWER_LOSS_FAULT = 6'h09;
  localparam logic [5:0] UNDERVOLTAGE_FAULT = 6'h0A;
  localparam logic [5:0] BRAKE_TRANSISTOR_FAULT = 6'h0B;
  localparam logic [5:0] GROUND_FAULT = 6'h0C;
  localparam logic [5:0] EXTERNAL_THERMAL_FAULT = 6'h0E;
  localparam logic [5:0] STALL_STOP_FAULT = 6'h0F;
  localparam logic [5:0] OPTION_FAULT = 6'h10;
  localparam logic [5:0] RETRY_EXCESS_FAULT = 6'h16;
  localparam logic [5:0] OVERSPEED_FAULT = 6'h1A;
  localparam logic [5:0] SPEED_DEVIATION_FAULT = 6'h1B;
  localparam logic [5:0] BRAKE_DECEL_FAULT = 6'h20;
  localparam logic [5:0] BRAKE_GRAVITY_FAULT = 6'h21;
  localparam logic [5:0] SENSE_SUPPLY_SHORT_FAULT = 6'h28;

  // Class selector and count setting encodings.
  localparam logic [2:0] CLASS_MAX = 3'h5;
  localparam logic [6:0] COUNT_QUIET_MIN = 7'h01;
  localparam logic [6:0] COUNT_QUIET_MAX = 7'h0A;
  localparam logic [6:0] COUNT_LOUD_MIN = 7'h65;
  localparam logic [6:0] COUNT_LOUD_MAX = 7'h6E;
  localparam logic [6:0] COUNT_LOUD_BASE = 7'h64;

  // Wait time is in 0.1 s steps, 0 to 10 s.
  localparam int unsigned WAIT_STEP_MS = 100;
  localparam int unsigned CORE_CLK_KHZ = 125000;
  localparam int unsigned WAIT_STEP_CYCLES = WAIT_STEP_MS * CORE_CLK_KHZ;
  localparam logic [6:0] WAIT_MAX = 7'h64;
  localparam logic [6:0] WAIT_DEFAULT = 7'h0A;
  localparam logic [1:0] WATCH_SHIFT = 2'h2;

  typedef enum logic [1:0] {
    FARC_IDLE,
    FARC_WAIT,
    FARC_WATCH,
    FARC_HALT
  } farc_st_t;

  typedef struct packed {
    farc_st_t st;
    logic [3:0] attempts;
    logic [31:0] prescale;
    logic [9:0] steps;
    logic [15:0] success_cnt;
    logic [5:0] first_fault;
    logic seq_active;
    logic alarm;
    logic excess;
    logic retry_reset;
    logic restart;
  } farc_state_t;

  // Permitted retries for a count setting; out-of-range settings disable retry.
  function automatic logic [3:0] farc_limit(input logic [6:0] setting);
    logic [6:0] diff;
    diff = setting - COUNT_LOUD_BASE;
    if (setting >= COUNT_QUIET_MIN && setting <= COUNT_QUIET_MAX) begin
      farc_limit = setting[3:0];
    end else if (setting >= COUNT_LOUD_MIN && setting <= COUNT_LOUD_MAX) begin
      farc_limit = diff[3:0];
    end else begin
      farc_limit = 4'h0;
    end
  endfunction

  function automatic logic farc_loud(input logic [6:0] setting);
    farc_loud = setting >= COUNT_LOUD_MIN && setting <= COUNT_LOUD_MAX;
  endfunction

endpackage

// *** farc_class_decode.sv ***
// Combinational decoder: does a fault code qualify for retry under a class setting.
// Assumes code and class are stable in the cycle they are sampled.
module farc_class_decode
  import farc_pkg::*;
(
  // Query.
  input wire logic [2:0] i_class,
  input wire logic [5:0] i_code,
  // Answer.
  output logic o_retry_ok
);

  logic oc;
  logic ov;

  always_comb begin
    oc = i_code == ACCEL_OVERCURRENT_FAULT || i_code == CONST_SPEED_OVERCURRENT_FAULT ||
         i_code == DECEL_OVERCURRENT_FAULT;
    ov = i_code == ACCEL_OVERVOLTAGE_FAULT || i_code == CONST_SPEED_OVERVOLTAGE_FAULT ||
         i_code == DECEL_OVERVOLTAGE_FAULT;
    // Any code not named below, storage through supply shorts, never retries. [R6]
    case (i_class)
      3'h0: o_retry_ok = oc || ov || i_code == MOTOR_THERMAL_FAULT ||
                         i_code == TRANSISTOR_THERMAL_FAULT || i_code == POWER_LOSS_FAULT ||
                         i_code == BRAKE_TRANSISTOR_FAULT || i_code == EXTERNAL_THERMAL_FAULT ||
                         i_code == STALL_STOP_FAULT || i_code == OPTION_FAULT ||
                         i_code == OVERSPEED_FAULT || i_code == BRAKE_DECEL_FAULT; // [R3]
      3'h1: o_retry_ok = oc; // [R4]
      3'h2: o_retry_ok = i_code == ACCEL_OVERVOLTAGE_FAULT ||
                         i_code == CONST_SPEED_OVERVOLTAGE_FAULT; // [R4]
      3'h3: o_retry_ok = i_code == ACCEL_OVERVOLTAGE_FAULT; // [R4]
      3'h4: o_retry_ok = oc || ov || i_code == UNDERVOLTAGE_FAULT ||
                         i_code == BRAKE_TRANSISTOR_FAULT || i_code == GROUND_FAULT ||
                         i_code == OVERSPEED_FAULT || i_code == SPEED_DEVIATION_FAULT ||
                         i_code == BRAKE_DECEL_FAULT || i_code == BRAKE_GRAVITY_FAULT; // [R5]
      3'h5: o_retry_ok = i_code == DECEL_OVERCURRENT_FAULT; // [R4]
      default: o_retry_ok = 1'b0;
    endcase
  end

endmodule

// *** farc_top.sv ***
// Fault auto-retry controller: waits, self-resets and restarts after a major fault.
// Assumes fault events and settings come from logic on i_core_clk; reset is a pin.
//
// Function
// R1: After a retryable major fault the block self-resets and restarts the drive.
// R2: Class selector 0 to 5, default 0, picks which faults retry.
// R3: Class 0 retries all but undervoltage and ground faults among the listed set; the code also excludes speed deviation and brake gravity.
// R4: Classes 1, 2, 3, 5 retry overcurrent or overvoltage subsets only.
// R5: Class 4 adds undervoltage, ground, deviation and brake faults, drops thermal.
// R6: Storage, panel, processor, fan, encoder and similar faults never retry.
// R7: Count setting 0, 1-10 or 101-110; zero disables retry.
// R8: 1-10 keeps alarm quiet per retry; 101-110 alarms each time.
// R9: A qualifying fault beyond the permitted retries raises retry excess.
// R10: Retry follows a wait of 0 to 10 s, default 1 s.
// R11: Success count is readable and cleared by writing zero.
// R12: Success counts one after four waits of fault-free running after retry.
// R13: During a fault sequence only the first fault is recorded.
// R14: Retry reset keeps thermal and other accumulated data.
// R15: A successful retry clears the consumed attempt count.
module farc_top
  import farc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = WAIT_STEP_CYCLES
)
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Faults from the protective logic.
  input wire logic i_fault_valid,
  input wire logic [5:0] i_fault_code,
  input wire logic i_fault_reset,
  // Settings.
  input wire logic [2:0] i_retry_class_select,
  input wire logic [6:0] i_retry_count_setting,
  input wire logic [6:0] i_retry_wait_time,
  input wire logic i_success_clear,
  // Status and actions.
  output logic o_retry_reset,
  output logic o_restart,
  output logic o_alarm,
  output logic o_retry_excess_fault,
  output logic [15:0] o_retry_success_counter,
  output logic [5:0] o_first_retry_fault,
  output logic [3:0] o_attempts
);

  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  logic rst_meta_q;
  logic rst_sync_q;
  farc_state_t s_q;
  farc_state_t s_d;
  logic retry_ok;
  logic [6:0] wait_steps;
  logic [9:0] watch_steps;
  logic [3:0] limit;
  logic tick;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // The class is decoded fresh at each fault, so a class change mid-sequence applies next.
  farc_class_decode farc_class_decode_i (
    .i_class(i_retry_class_select),
    .i_code(i_fault_code),
    .o_retry_ok(retry_ok)
  );

  always_comb begin
    s_d = s_q;
    s_d.retry_reset = 1'b0;
    s_d.restart = 1'b0;
    limit = farc_limit(i_retry_count_setting); // [R7]
    wait_steps = (i_retry_wait_time > WAIT_MAX) ? WAIT_MAX : i_retry_wait_time; // [R10]
    watch_steps = {3'h0, wait_steps} << WATCH_SHIFT; // [R12]
    tick = s_q.prescale == TICK_LAST;
    s_d.prescale = tick ? 32'h0 : s_q.prescale + 32'h1;
    if (tick) begin
      s_d.steps = s_q.steps + 10'h1;
    end
    case (s_q.st)
      FARC_IDLE, FARC_WATCH: begin
        if (i_fault_valid) begin
          s_d.prescale = 32'h0;
          s_d.steps = 10'h0;
          if (!s_q.seq_active) begin
            s_d.first_fault = i_fault_code; // [R13]
          end
          s_d.seq_active = 1'b1;
          if (!retry_ok || limit == 4'h0) begin
            s_d.st = FARC_HALT; // [R2] [R7]
            s_d.alarm = 1'b1;
          end else if (s_q.attempts >= limit) begin
            s_d.st = FARC_HALT; // [R9]
            s_d.excess = 1'b1;
            s_d.alarm = 1'b1;
          end else begin
            s_d.st = FARC_WAIT; // [R1]
            s_d.attempts = s_q.attempts + 4'h1;
            s_d.alarm = farc_loud(i_retry_count_setting); // [R8]
          end
        end else if (s_q.st == FARC_WATCH && s_q.steps >= watch_steps) begin
          s_d.st = FARC_IDLE; // [R12]
          s_d.success_cnt = s_q.success_cnt + 16'h1;
          s_d.attempts = 4'h0; // [R15]
          s_d.seq_active = 1'b0;
        end
      end
      FARC_WAIT: begin
        // Output is already stopped here, so further faults add nothing.
        if ({3'h0, wait_steps} <= s_q.steps) begin
          s_d.st = FARC_WATCH; // [R10]
          s_d.retry_reset = 1'b1; // [R1] [R14]
          s_d.restart = 1'b1;
          s_d.alarm = 1'b0;
          s_d.prescale = 32'h0;
          s_d.steps = 10'h0;
        end
      end
      FARC_HALT: begin
        if (i_fault_reset) begin
          s_d.st = FARC_IDLE;
          s_d.attempts = 4'h0;
          s_d.seq_active = 1'b0;
          s_d.alarm = 1'b0;
          s_d.excess = 1'b0;
        end
      end
      default: s_d.st = FARC_HALT;
    endcase
    // A success landing with the clear is kept, so no successful retry goes uncounted.
    if (i_success_clear) begin
      s_d.success_cnt = (s_d.success_cnt != s_q.success_cnt) ? 16'h1 : 16'h0; // [R11]
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= '{st: FARC_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // The retry reset pulse is separate from power-on reset and clears nothing accumulated.
  assign o_retry_reset = s_q.retry_reset; // [R14]
  assign o_restart = s_q.restart;
  assign o_alarm = s_q.alarm;
  assign o_retry_excess_fault = s_q.excess;
  assign o_retry_success_counter = s_q.success_cnt;
  assign o_first_retry_fault = s_q.first_fault;
  assign o_attempts = s_q.attempts;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_sync_q);

  logic fault_idle;
  assign fault_idle = i_fault_valid && (s_q.st == FARC_IDLE || s_q.st == FARC_WATCH);

  excess_on_limit_a: assert property (fault_idle && retry_ok && limit != 4'h0 && // [R9]
      s_q.attempts >= limit |=> o_retry_excess_fault && o_alarm && s_q.st == FARC_HALT)
    else $error("retry excess not raised at limit");
  disabled_halts_a: assert property (fault_idle && limit == 4'h0 // [R7]
      |=> s_q.st == FARC_HALT && !o_restart)
    else $error("retry happened with retries disabled");
  loud_alarm_a: assert property (fault_idle && retry_ok && s_q.attempts < limit && // [R8]
      farc_loud(i_retry_count_setting) |=> o_alarm && s_q.st == FARC_WAIT)
    else $error("alarm missing in every-time mode");
  quiet_alarm_a: assert property (fault_idle && retry_ok && s_q.attempts < limit && // [R8]
      !farc_loud(i_retry_count_setting) |=> !o_alarm ##1 !o_alarm)
    else $error("alarm raised in quiet retry mode");
  zero_wait_a: assert property ($rose(s_q.st == FARC_WAIT) && i_retry_wait_time == 7'h00 // [R10]
      |=> o_restart && o_retry_reset ##1 !o_restart)
    else $error("zero wait did not restart at once");
  success_step_a: assert property (!$past(i_success_clear) && // [R12]
      o_retry_success_counter != $past(o_retry_success_counter)
      |-> o_retry_success_counter == $past(o_retry_success_counter) + 16'h1 &&
          $past(s_q.st) == FARC_WATCH)
    else $error("success count moved wrongly");
  count_clear_a: assert property (i_success_clear && s_q.st != FARC_WATCH // [R11]
      |=> o_retry_success_counter == 16'h0)
    else $error("success count not cleared");
  first_kept_a: assert property (i_fault_valid && s_q.seq_active // [R13]
      |=> $stable(o_first_retry_fault))
    else $error("first fault overwritten in sequence");
  attempts_cleared_a: assert property (s_q.st == FARC_WATCH && // [R15]
      $past(s_q.st) == FARC_WATCH && s_d.st == FARC_IDLE |=> o_attempts == 4'h0)
    else $error("attempts kept after success");
  nonretry_halts_a: assert property (fault_idle && !retry_ok // [R6]
      |=> s_q.st == FARC_HALT && o_alarm ##1 !o_restart)
    else $error("non-retryable fault did not halt");
  retry_starts_a: assert property (fault_idle && retry_ok && s_q.attempts < limit // [R1]
      |=> s_q.st == FARC_WAIT && o_attempts == $past(s_q.attempts) + 4'h1)
    else $error("retry did not start on a qualifying fault");
  wait_held_a: assert property (s_q.st == FARC_WAIT && {3'h0, wait_steps} > s_q.steps // [R10]
      |=> !o_restart)
    else $error("restart came before the wait ended");
  halt_kept_a: assert property (s_q.st == FARC_HALT && !i_fault_reset // [R9]
      |=> o_alarm && s_q.st == FARC_HALT)
    else $error("halt left without operator reset");

  retry_success_c: cover property (o_restart ##[1:8] o_retry_success_counter != 16'h0);
  excess_hit_c: cover property ($rose(o_retry_excess_fault));
  class4_ground_c: cover property (fault_idle && i_retry_class_select == 3'h4 &&
      i_fault_code == GROUND_FAULT && retry_ok);
  class7_halt_c: cover property (fault_idle && i_retry_class_select == 3'h7 ##1
      s_q.st == FARC_HALT);

endmodule

// *** farc_fault_src.sv ***
// Partner model: the protective logic that stops the output and reports a fault code.
// Assumes its caller runs on the core clock and calls raise() from one process.
module farc_fault_src (
  // Clock.
  input wire logic i_clk,
  // Fault event.
  output logic o_fault_valid,
  output logic [5:0] o_fault_code
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_fault_valid = 1'b0;
    o_fault_code = 6'h00;
  end
  // After each pulse the code is left inverted, so a stale code can never pass as valid.
  task automatic raise(input logic [5:0] code);
    @(posedge i_clk);
    #1;
    o_fault_valid = 1'b1;
    o_fault_code = code;
    @(posedge i_clk);
    #1;
    o_fault_valid = 1'b0;
    o_fault_code = ~code;
  endtask
endmodule

// *** farc_top_bench.sv ***
// Self-checking bench for the fault auto-retry controller.
// Assumes a shortened wait tick; the fault source is the partner model.
module farc_top_bench
  import farc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TICK = 4;
  localparam logic [5:0] CODES [22] = '{ACCEL_OVERCURRENT_FAULT, CONST_SPEED_OVERCURRENT_FAULT,
    DECEL_OVERCURRENT_FAULT, ACCEL_OVERVOLTAGE_FAULT, CONST_SPEED_OVERVOLTAGE_FAULT,
    DECEL_OVERVOLTAGE_FAULT, MOTOR_THERMAL_FAULT, TRANSISTOR_THERMAL_FAULT, POWER_LOSS_FAULT,
    BRAKE_TRANSISTOR_FAULT, EXTERNAL_THERMAL_FAULT, STALL_STOP_FAULT, OPTION_FAULT,
    OVERSPEED_FAULT, BRAKE_DECEL_FAULT, UNDERVOLTAGE_FAULT, GROUND_FAULT, SPEED_DEVIATION_FAULT,
    BRAKE_GRAVITY_FAULT, RETRY_EXCESS_FAULT, SENSE_SUPPLY_SHORT_FAULT, 6'h3F};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic fault_valid, fault_reset = 1'b0, success_clear = 1'b0;
  logic [5:0] fault_code;
  logic [2:0] class_sel = 3'h0;
  logic [6:0] count_set = 7'h01, wait_set = 7'h00;
  logic retry_reset, restart, alarm, excess;
  logic [15:0] success_cnt;
  logic [5:0] first_fault;
  logic [3:0] attempts;
  int n_fail = 0, n_compared = 0, cyc = 0, seed = 77836, n, lim, w, exp_cnt = 0;
  logic [5:0] code, first;
  logic loud;
  logic [9:0] notes [$];
  logic [9:0] note;
  always #4 core_clk = ~core_clk;
  farc_top #(.TICK_CYCLES(TICK)) farc_top_i (.i_core_clk(core_clk), .i_rstn(rst_n),
    .i_fault_valid(fault_valid), .i_fault_code(fault_code), .i_fault_reset(fault_reset),
    .i_retry_class_select(class_sel), .i_retry_count_setting(count_set),
    .i_retry_wait_time(wait_set), .i_success_clear(success_clear), .o_retry_reset(retry_reset),
    .o_restart(restart), .o_alarm(alarm), .o_retry_excess_fault(excess),
    .o_retry_success_counter(success_cnt), .o_first_retry_fault(first_fault),
    .o_attempts(attempts));
  farc_fault_src farc_fault_src_i (.i_clk(core_clk), .o_fault_valid(fault_valid),
    .o_fault_code(fault_code));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("failures %0d comparisons %0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_rs(output int cnt);
    cnt = 0;
    while (restart !== 1'b1 && cnt < 200) begin
      step(1);
      cnt++;
    end
  endtask
  task automatic clr_halt();
    fault_reset = 1'b1;
    step(1);
    fault_reset = 1'b0;
    step(2);
  endtask
  function automatic logic exp_ok(input logic [2:0] c, input int i);
    case (c)
      3'h0: return i < 15;
      3'h1: return i < 3;
      3'h2: return i == 3 || i == 4;
      3'h3: return i == 3;
      3'h4: return i < 6 || i == 9 || i == 13 || (i > 13 && i < 19);
      3'h5: return i == 2;
      default: return 1'b0;
    endcase
  endfunction
  // Every restart pulse must match the oldest expected attempt count and first fault.
  always @(posedge core_clk) begin
    if (restart === 1'b1) begin
      if (notes.size() == 0) check(16'h0001, 16'h0000);
      else begin
        note = notes.pop_front();
        check({6'h00, attempts, first_fault}, {6'h00, note});
        check({15'h0000, retry_reset}, 16'h0001);
      end
    end
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    step(4);
    check(success_cnt, 16'h0000);
    check({10'h000, attempts, excess, alarm}, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      class_sel = c[2:0];
      for (int i = 0; i < 22; i++) begin
        if (exp_ok(c[2:0], i)) begin
          notes.push_back({4'h1, CODES[i]});
          farc_fault_src_i.raise(CODES[i]);
          wait_rs(n);
          step(3);
          exp_cnt++;
          check(success_cnt, exp_cnt[15:0]);
          check({12'h000, attempts}, 16'h0000);
        end else begin
          farc_fault_src_i.raise(CODES[i]);
          step(3);
          check({15'h0000, alarm}, 16'h0001);
          clr_halt();
        end
      end
    end
    class_sel = 3'h0;
    wait_set = 7'h01;
    for (int p = 0; p < 2; p++) begin
      loud = p[0];
      lim = 1 + ($random(seed) & 7);
      count_set = loud ? COUNT_LOUD_BASE + lim[6:0] : lim[6:0];
      for (int k = 1; k <= lim + 1; k++) begin
        code = CODES[($random(seed) & 15) % 15];
        if (k == 1) first = code;
        if (k <= lim) notes.push_back({k[3:0], first});
        farc_fault_src_i.raise(code);
        step(2);
        if (k <= lim) begin
          check({15'h0000, alarm}, {15'h0000, loud});
          wait_rs(n);
        end
      end
      check({14'h0000, excess, alarm}, 16'h0003);
      clr_halt();
      check({15'h0000, excess}, 16'h0000);
    end
    count_set = 7'h00;
    farc_fault_src_i.raise(ACCEL_OVERCURRENT_FAULT);
    step(3);
    check({15'h0000, alarm}, 16'h0001);
    clr_halt();
    count_set = 7'h05;
    w = 1 + ($random(seed) & 1);
    wait_set = w[6:0];
    for (int p = 0; p < 2; p++) begin
      notes.push_back({4'h1, ACCEL_OVERVOLTAGE_FAULT});
      farc_fault_src_i.raise(ACCEL_OVERVOLTAGE_FAULT);
      // A non-retryable second fault while the output is stopped must not halt the retry in progress.
      if (p == 1) farc_fault_src_i.raise(GROUND_FAULT);
      wait_rs(n);
      if (p == 0) check({15'h0000, n >= w * TICK && n <= w * TICK + 3}, 16'h0001);
      step(16 * w - 3);
      check(success_cnt, exp_cnt[15:0]);
      step(8);
      exp_cnt++;
      check(success_cnt, exp_cnt[15:0]);
    end
    success_clear = 1'b1;
    step(1);
    success_clear = 1'b0;
    step(2);
    check(success_cnt, 16'h0000);
    stop_test();
  end
endmodule
